/* File: hdl/dsc_serial_port.sv */
// serial configuration port: instruction byte, then 1..4 data bytes on one data pin
// assumes serial clock well below core clock/4 (20 MHz max vs 125 MHz core)
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - every cycle starts with an 8-bit instruction on the first eight rising edges
// - instruction decodes direction, byte count and first register address
// - mode/reset pulse high then low restarts at instruction phase
// - partial bits at a mode/reset pulse are discarded, never written
// - data phase moves exactly one to four bytes per the count
// - each written byte updates its register on its final bit
// - one shared data pin receives commands and drives read data
// - msb-first or lsb-first bit order chosen by configuration bit
// - every configuration register is readable and writable, single or multibyte
// - bit7 read flag, bits6..5 count minus one, bits4..0 address
// - sample on rising serial clock, launch on falling; clock at most 20 MHz
// - select held low for whole cycle; data pin released while high
// - address decrements per byte when msb-first, increments when lsb-first
module dsc_serial_port (
	// core clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         srst,
	// serial pins
	input  wire logic                         sclkPin,
	input  wire logic                         select_n,
	input  wire logic                         modeResetPin,
	input  wire logic                         sdioIn,
	output var  logic                         sdioOut,
	output var  logic                         sdioOe,
	// register contents to the converter core
	output var  logic [dsc_pkg::BYTE_BITS-1:0] ctrlReg,
	output var  logic                         busy
);
	import dsc_pkg::*;

	localparam int PIN_COUNT = 4;

	// synchronised pins and their delayed copies for edge detection
	logic [PIN_COUNT-1:0] pinRaw;
	logic [PIN_COUNT-1:0] pinSync;
	logic                 sclkS;
	logic                 selNS;
	logic                 modeS;
	logic                 sdioS;
	logic                 sclkD;
	logic                 modeD;
	// register file, one byte per address
	logic [BYTE_BITS-1:0] regs      [REG_COUNT];
	logic [BYTE_BITS-1:0] next_regs [REG_COUNT];
	// sequencer state
	dsc_state_t           state;
	dsc_state_t           next_state;
	logic [BYTE_BITS-1:0] shiftReg;
	logic [BYTE_BITS-1:0] next_shiftReg;
	logic [BYTE_BITS-1:0] outReg;
	logic [BYTE_BITS-1:0] next_outReg;
	logic [2:0]           bitCnt;
	logic [2:0]           next_bitCnt;
	logic [1:0]           byteCnt;
	logic [1:0]           next_byteCnt;
	logic [ADDR_BITS-1:0] addr;
	logic [ADDR_BITS-1:0] next_addr;
	logic                 readOp;
	logic                 next_readOp;
	logic                 next_sdioOut;
	logic                 next_sdioOe;
	logic                 next_busy;
	// decoded strobes
	logic                 sclkRise;
	logic                 sclkFall;
	logic                 modeFall;
	logic                 lsbFirst;
	logic [BYTE_BITS-1:0] rxByte;

	// every external pin is synchronised before use; one synchroniser per pin
	assign pinRaw = {sdioIn, modeResetPin, select_n, sclkPin};
	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++)
		begin : gSync
			dsc_sync uSync (.clk(core_clk), .srst(srst), .pinIn(pinRaw[g]), .pinOut(pinSync[g]));
		end
	endgenerate
	// select reads as low for two clocks after reset; harmless, no clock edge is seen meanwhile
	assign sclkS = pinSync[0];
	assign selNS = pinSync[1];
	assign modeS = pinSync[2];
	assign sdioS = pinSync[3];

	// address of the following byte: msb-first walks down, lsb-first walks up, wrapping at five bits
	function automatic logic [ADDR_BITS-1:0] stepAddr(input logic [ADDR_BITS-1:0] cur, input logic lsb);
		stepAddr = lsb ? cur + ADDR_STEP : cur - ADDR_STEP;
	endfunction

	// bit-order aware byte assembly, used for receive only; transmit shifts outReg directly
	function automatic logic [BYTE_BITS-1:0] shiftIn(input logic [BYTE_BITS-1:0] cur,
		input logic b, input logic lsb);
		shiftIn = lsb ? {b, cur[BYTE_BITS-1:1]} : {cur[BYTE_BITS-2:0], b};
	endfunction

	// edge detect works on synchronised copies only
	assign sclkRise = sclkS & ~sclkD;
	assign sclkFall = ~sclkS & sclkD;
	assign modeFall = ~modeS & modeD;
	assign lsbFirst = regs[ADDR_CTRL][CTRL_ORDER_POS];
	assign rxByte   = shiftIn(shiftReg, sdioS, lsbFirst);

	// sequencer and register file next values
	always_comb
	begin
		next_state    = state;
		next_shiftReg = shiftReg;
		next_outReg   = outReg;
		next_bitCnt   = bitCnt;
		next_byteCnt  = byteCnt;
		next_addr     = addr;
		next_readOp   = readOp;
		next_sdioOut  = sdioOut;
		next_sdioOe   = sdioOe;
		next_regs     = regs;
		if (modeS || modeFall || selNS)
		begin
			// restart discards partial bits without a write; select high releases the pin
			next_state   = DSC_INSTR;
			next_bitCnt  = '0;
			next_shiftReg = '0;
			next_sdioOe  = 1'b0;
			next_sdioOut = 1'b0;
		end
		else
		begin
			case (state)
			DSC_INSTR:
				if (sclkRise)
				begin
					next_shiftReg = rxByte;
					next_bitCnt   = bitCnt + 3'h1;
					if (bitCnt == BIT_CNT_LAST)
					begin
						next_readOp  = rxByte[INS_DIR_POS];
						next_byteCnt = {rxByte[INS_CNT_HI_POS], rxByte[INS_CNT_LO_POS]};
						next_addr    = rxByte[ADDR_BITS-1:0];
						next_outReg  = regs[rxByte[ADDR_BITS-1:0]];
						next_state   = DSC_DATA;
					end
				end
			DSC_DATA:
			begin
				if (sclkFall && readOp)
				begin
					// launch next read bit on falling edge
					next_sdioOe  = 1'b1;
					next_sdioOut = lsbFirst ? outReg[0] : outReg[BYTE_BITS-1];
				end
				if (sclkRise)
				begin
					next_shiftReg = rxByte;
					next_bitCnt   = bitCnt + 3'h1;
					next_outReg   = lsbFirst ? (outReg >> 1) : (outReg << 1);
					if (bitCnt == BIT_CNT_LAST)
					begin
						if (!readOp)
							next_regs[addr] = rxByte;
						next_addr = stepAddr(addr, lsbFirst);
						// prefetch the next read byte so its first bit is ready at the coming fall
						next_outReg = regs[stepAddr(addr, lsbFirst)];
						next_byteCnt = byteCnt - CNT_STEP;
						if (byteCnt == '0)
							next_state = DSC_DONE;
					end
				end
			end
			default:
			begin
				// ignore clocks until select goes high again
				if (sclkFall)
					next_sdioOe = 1'b0;
			end
			endcase
		end
		next_busy = (next_state != DSC_INSTR) || (next_bitCnt != '0);
	end

	// registering of all sequencer state
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			sclkD    <= 1'b0;
			modeD    <= 1'b0;
			state    <= DSC_INSTR;
			shiftReg <= '0;
			outReg   <= '0;
			bitCnt   <= '0;
			byteCnt  <= '0;
			addr     <= '0;
			readOp   <= 1'b0;
			sdioOut  <= 1'b0;
			sdioOe   <= 1'b0;
			busy     <= 1'b0;
			ctrlReg  <= CTRL_RESET;
			for (int i = 0; i < REG_COUNT; i++)
				regs[i] <= (i == ADDR_CTRL) ? CTRL_RESET : REG_RESET;
		end
		else
		begin
			sclkD    <= sclkS;
			modeD    <= modeS;
			state    <= next_state;
			shiftReg <= next_shiftReg;
			outReg   <= next_outReg;
			bitCnt   <= next_bitCnt;
			byteCnt  <= next_byteCnt;
			addr     <= next_addr;
			readOp   <= next_readOp;
			sdioOut  <= next_sdioOut;
			sdioOe   <= next_sdioOe;
			busy     <= next_busy;
			ctrlReg  <= next_regs[ADDR_CTRL];
			regs     <= next_regs;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/dsc_pkg.sv */
// constants for the serial configuration port
// assumes a single core clock; serial pins arrive asynchronously
package dsc_pkg;
	localparam int          BYTE_BITS      = 8;
	localparam int          ADDR_BITS      = 5;
	localparam int          REG_COUNT      = 32;
	localparam logic [2:0]  BIT_CNT_LAST   = 3'h7;
	localparam int          INS_DIR_POS    = 7;
	localparam int          INS_CNT_HI_POS = 6;
	localparam int          INS_CNT_LO_POS = 5;
	localparam logic [4:0]  ADDR_CTRL      = 5'h00;
	localparam int          CTRL_ORDER_POS = 6;
	localparam logic [7:0]  CTRL_RESET     = 8'h80;
	localparam logic [7:0]  REG_RESET      = 8'h00;
	localparam logic [4:0]  ADDR_STEP      = 5'h01;
	localparam logic [1:0]  CNT_STEP       = 2'h1;
	localparam int          SCLK_MAX_MHZ   = 20;
	typedef enum logic [1:0] {DSC_INSTR, DSC_DATA, DSC_DONE} dsc_state_t;
endpackage

/* File: hdl/dsc_sync.sv */
// two-flop synchroniser for one asynchronous pin
// assumes clk is the core clock
`timescale 1ns/100ps
`default_nettype none
module dsc_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// pin in, synchronised level out
	input  wire logic pinIn,
	output var  logic pinOut
);
	logic stage1;
	logic next_stage1;
	logic next_pinOut;

	// first stage feeds only the second
	always_comb
	begin
		next_stage1 = pinIn;
		next_pinOut = stage1;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			stage1 <= 1'b0;
			pinOut <= 1'b0;
		end
		else
		begin
			stage1 <= next_stage1;
			pinOut <= next_pinOut;
		end
	end
endmodule
`default_nettype wire

/* File: verif/dsc_checker.sv */
// assertions on the serial port pins
// assumes a bind onto dsc_serial_port, pins synchronised in two flops
`timescale 1ns/100ps
`default_nettype none
module dsc_checker (
	// core
	input wire logic       core_clk,
	input wire logic       srst,
	// serial pins and outputs
	input wire logic       sclkPin,
	input wire logic       select_n,
	input wire logic       modeResetPin,
	input wire logic       sdioOut,
	input wire logic       sdioOe,
	input wire logic [7:0] ctrlReg,
	input wire logic       busy
);
	import dsc_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// five cycles covers the synchroniser plus the output flop
	reset_vals_a: assert property ($fell(srst) |-> ctrlReg == CTRL_RESET && !sdioOe && !busy)
		else $error("bad reset state");
	oe_idle_a: assert property (select_n [*5] |-> !sdioOe)
		else $error("pin driven unselected");
	idle_busy_a: assert property (select_n [*5] |-> !busy)
		else $error("busy unselected");
	mode_hold_a: assert property (modeResetPin [*5] |-> !sdioOe && !busy)
		else $error("busy in mode reset");
	launch_fall_a: assert property (sdioOe && ($changed(sdioOut) || $rose(sdioOe)) |-> !sclkPin)
		else $error("launch off falling edge");
	ctrl_write_a: assert property ($changed(ctrlReg) |-> sclkPin && !select_n)
		else $error("ctrl changed off byte end");
	oe_read_a: assert property ($rose(sdioOe) |-> busy)
		else $error("drive outside cycle");
	busy_sel_a: assert property ($rose(busy) |-> !select_n)
		else $error("busy without select");
endmodule
bind dsc_serial_port dsc_checker dsc_checker_i (.core_clk, .srst, .sclkPin, .select_n, .modeResetPin, .sdioOut,
	.sdioOe, .ctrlReg, .busy);
`default_nettype wire

/* File: verif/dsc_master.sv */
// serial master model: instruction byte then data bits, one frame per call
// assumes sdi is the resolved data wire; sclk stands low between frames
`timescale 1ns/100ps
`default_nettype none
module dsc_master (
	// serial pins
	output var logic        sclk,
	output var logic        selN,
	output var logic        sdo,
	input  wire logic       sdi,
	// read result
	output var logic [39:0] rdData,
	output var logic        rdValid
);
	initial
	begin
		sclk = 1'b0;
		selN = 1'b1;
		sdo = 1'b0;
		rdData = 40'h0;
		rdValid = 1'b0;
	end
	// 160 ns bit period keeps under the 20 MHz ceiling; select low for the whole frame
	task automatic frame(input logic [39:0] v, input int nBits, input logic lsb, input logic rd);
		int k;
		rdData = 40'h0;
		selN = 1'b0;
		for (int i = 0; i < nBits; i++)
		begin
			k = 39 - 8 * (i / 8) - (lsb ? 7 - i % 8 : i % 8);
			sdo = rd && i > 7 ? ~sdo : v[k]; // released line keeps changing
			#80 sclk = 1'b1;
			rdData[k] = sdi;
			#80 sclk = 1'b0;
		end
		#80 selN = 1'b1;
		rdValid = rd;
		#8 rdValid = 1'b0;
		// keep select high long enough for the synchroniser to see the gap
		#80;
	endtask
endmodule
`default_nettype wire

/* File: verif/test_dac_serial_config_port.sv */
// bench for the serial configuration port driven by the master model
// assumes dsc_master owns the link; read results are matched from a queue
`timescale 1ns/100ps
`default_nettype none
module test_dac_serial_config_port;
	import dsc_pkg::*;
	logic        core_clk, srst, modeResetPin, sclk, selN, sdo, sdioOut, sdioOe, busy, rdValid;
	logic [7:0]  ctrlReg;
	logic [39:0] rdData;
	logic [31:0] seed = 32'h2a;
	logic [31:0] expQ[$];
	int          failCount, checksDone, cycles;
	wire logic   sdioIn = sdioOe ? sdioOut : sdo;
	dsc_serial_port dsc_serial_port_i (.core_clk, .srst, .sclkPin(sclk), .select_n(selN), .modeResetPin, .sdioIn,
		.sdioOut, .sdioOe, .ctrlReg, .busy);
	dsc_master dsc_master_i (.sclk, .selN, .sdo, .sdi(sdioIn), .rdData, .rdValid);
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// ceiling well above the roughly 9.5k cycles of traffic
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			failCount++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		// a read that never completed leaves an expectation behind
		if (expQ.size() != 0)
			failCount++;
		$display("checks %0d mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk32(input logic [31:0] e, input logic [31:0] s);
		checksDone++;
		if (s !== e)
		begin
			failCount++;
			$display("BAD read data exp %h got %h", e, s);
		end
	endtask
	task automatic chk8(input logic [7:0] e);
		checksDone++;
		if (ctrlReg !== e)
		begin
			failCount++;
			$display("BAD ctrlReg exp %h got %h", e, ctrlReg);
		end
	endtask
	// each finished read is matched against the oldest expectation
	always @(posedge rdValid)
		chk32(expQ.pop_front(), rdData[31:0]);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// write n random bytes, read them back, then for n above 1 read the neighbour the address stepped to
	task automatic wr_rd(input logic [4:0] a, input int n, input logic lsb);
		logic [31:0] d;
		seed = lfsr(seed);
		d = seed & ~(32'hffffffff >> (8 * n));
		dsc_master_i.frame({1'b0, 2'(n - 1), a, d}, 8 + 8 * n, lsb, 1'b0);
		expQ.push_back(d);
		dsc_master_i.frame({1'b1, 2'(n - 1), a, 32'h0}, 8 + 8 * n, lsb, 1'b1);
		if (n > 1)
		begin
			expQ.push_back({d[23:16], 24'h0});
			dsc_master_i.frame({3'h4, lsb ? a + 5'h01 : a - 5'h01, 32'h0}, 16, lsb, 1'b1);
		end
	endtask
	initial
	begin
		srst = 1'b1;
		modeResetPin = 1'b0;
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk8(8'h80);
		// move link edges off the core clock edge so pins never change as they are sampled
		#1;
		for (int n = 1; n <= 4; n++)
			wr_rd(5'(4 * n + 3), n, 1'b0);
		dsc_master_i.frame({8'h00, 8'hc0, 24'h0}, 16, 1'b0, 1'b0);
		chk8(8'hc0);
		wr_rd(5'h03, 2, 1'b1);
		dsc_master_i.frame({8'h00, 8'h80, 24'h0}, 16, 1'b1, 1'b0);
		chk8(8'h80);
		// extra clocks after a one-byte write must not reach the next register
		dsc_master_i.frame({8'h1c, 8'h5a, 8'ha5, 16'h0}, 32, 1'b0, 1'b0);
		expQ.push_back(32'h5a000000);
		dsc_master_i.frame({8'hbc, 32'h0}, 24, 1'b0, 1'b1);
		// mode pulse four bits into the data byte: nothing may be written
		fork
			dsc_master_i.frame({8'h1e, 8'hff, 24'h0}, 16, 1'b0, 1'b0);
			begin
				#1925 @(posedge core_clk) modeResetPin <= 1'b1;
				repeat (6) @(posedge core_clk);
				modeResetPin <= 1'b0;
			end
		join
		expQ.push_back(32'h0);
		dsc_master_i.frame({8'h9e, 32'h0}, 16, 1'b0, 1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
